// >>> verilog/pgtm_top.sv
// Power-good tree masks, termination discharge and aux/switch control
`timescale 1ns/1ps
`include "pgtm_defines.svh"
module pgtm_top #(
  // Factory variant, 0 to 3
  parameter int VARIANT      = 0,
  // Shutdown hold-off in milliseconds, factory choice
  parameter int SDWN_MS      = `PGTM_T_SDWN_MIN_MS,
  // Hold-off in clock cycles, shorten for simulation
  parameter int SDWN_CYCLES  = SDWN_MS * (`PGTM_NS_PER_MS /
                                          `PGTM_CLK_PERIOD_NS),
  // Width of the hold-off counter
  parameter int SDWN_CNT_W   = 24
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Register access from the serial management interface
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Control input pin states
  input  wire logic       control_input_1,
  input  wire logic       control_input_2,
  input  wire logic       control_input_3,
  input  wire logic       control_input_4,
  input  wire logic       control_input_5,
  input  wire logic       control_input_6,
  // Rail power-good sources
  input  wire logic       ddr_termination_regulator_pg,
  input  wire logic       load_switch_b1_pg,
  input  wire logic       load_switch_b2_pg,
  input  wire logic       aux_regulator_1_pg,
  input  wire logic       aux_regulator_3_pg,
  // Results of the masks held in other registers, one per output
  input  wire logic       other_tree_good_1,
  input  wire logic       other_tree_good_2,
  input  wire logic       other_tree_good_3,
  input  wire logic       other_tree_good_4,
  // Emergency shutdown request, level
  input  wire logic       emergency_shutdown,
  // Power-good output pins
  output logic            pg_output_1,
  output logic            pg_output_2,
  output logic            pg_output_3,
  output logic            pg_output_4,
  // Regulator and switch control
  output logic            termination_discharge_sel,
  output logic      [1:0] aux1_discharge_sel,
  output logic      [3:0] aux1_voltage_code,
  output logic            aux_or_switch_on
);

  // --------------------------------------------------------------------
  // Variant dependent constants
  // --------------------------------------------------------------------
  // Variant 3 routes switch B2 to the shared mask, the rest aux 1
  localparam bit SHARED_IS_SWITCH = (VARIANT == 3);
  // Variants 1 and 2 leave the enable and shutdown bits unused
  localparam bit AUX_SW_USED      = (VARIANT == 0) || (VARIANT == 3);

  localparam pgtm_pkg::pgtm_byte_t RST_OUT3 =
    (VARIANT == 0) ? `PGTM_RST_OUT3_MASK2_V0 :
    (VARIANT == 1) ? `PGTM_RST_OUT3_MASK2_V1 :
    (VARIANT == 2) ? `PGTM_RST_OUT3_MASK2_V2 : `PGTM_RST_OUT3_MASK2_V3;
  localparam pgtm_pkg::pgtm_byte_t RST_CTL =
    (VARIANT == 0) ? `PGTM_RST_CTL_MASK_V0 :
    (VARIANT == 1) ? `PGTM_RST_CTL_MASK_V1 :
    (VARIANT == 2) ? `PGTM_RST_CTL_MASK_V2 : `PGTM_RST_CTL_MASK_V3;
  localparam pgtm_pkg::pgtm_byte_t RST_TERM =
    (VARIANT == 0) ? `PGTM_RST_TERM_DISCH_V0 :
    (VARIANT == 1) ? `PGTM_RST_TERM_DISCH_V1 :
    (VARIANT == 2) ? `PGTM_RST_TERM_DISCH_V2 : `PGTM_RST_TERM_DISCH_V3;
  localparam pgtm_pkg::pgtm_byte_t RST_AUX =
    (VARIANT == 0) ? `PGTM_RST_AUX_SW_V0 :
    (VARIANT == 1) ? `PGTM_RST_AUX_SW_V1 :
    (VARIANT == 2) ? `PGTM_RST_AUX_SW_V2 : `PGTM_RST_AUX_SW_V3;

  // Hold-off reload value, at the counter's width
  localparam logic [SDWN_CNT_W-1:0] SDWN_LOAD =
    SDWN_CNT_W'(SDWN_CYCLES - 1);

  // Elaboration checks
  initial begin
    if (VARIANT < 0 || VARIANT > 3) begin
      $error("pgtm_top: VARIANT must be 0 to 3");
    end
    if (SDWN_CYCLES < 1 || SDWN_CYCLES >= (1 << SDWN_CNT_W)) begin
      $error("pgtm_top: SDWN_CYCLES does not fit the counter");
    end
  end

  // --------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------
  pgtm_pkg::pgtm_byte_t out3_mask2;
  pgtm_pkg::pgtm_byte_t ctl_mask;
  pgtm_pkg::pgtm_byte_t term_disch;
  pgtm_pkg::pgtm_byte_t aux_sw_ctrl;

  // Address decode of the write strobes
  logic hit_out3;
  logic hit_ctl;
  logic hit_term;
  logic hit_aux;
  assign hit_out3 = (reg_addr == `PGTM_OFF_OUT3_MASK2);
  assign hit_ctl  = (reg_addr == `PGTM_OFF_CTL_MASK);
  assign hit_term = (reg_addr == `PGTM_OFF_TERM_DISCH);
  assign hit_aux  = (reg_addr == `PGTM_OFF_AUX_SW_CTRL);

  // Reserved bits are stored as written; keeping them is software's job
  pgtm_reg8 #(.RESET_VAL(RST_OUT3)) u_out3_mask2 (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .wr_en   (reg_wr & hit_out3),
    .wr_data (reg_wdata),
    .value   (out3_mask2)
  );
  pgtm_reg8 #(.RESET_VAL(RST_CTL)) u_ctl_mask (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .wr_en   (reg_wr & hit_ctl),
    .wr_data (reg_wdata),
    .value   (ctl_mask)
  );
  pgtm_reg8 #(.RESET_VAL(RST_TERM)) u_term_disch (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .wr_en   (reg_wr & hit_term),
    .wr_data (reg_wdata),
    .value   (term_disch)
  );
  pgtm_reg8 #(.RESET_VAL(RST_AUX)) u_aux_sw_ctrl (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .wr_en   (reg_wr & hit_aux),
    .wr_data (reg_wdata),
    .value   (aux_sw_ctrl)
  );

  // Read selection, unmapped offsets read as zero
  pgtm_pkg::pgtm_byte_t rd_sel;
  assign rd_sel = hit_out3 ? out3_mask2  :
                  hit_ctl  ? ctl_mask    :
                  hit_term ? term_disch  :
                  hit_aux  ? aux_sw_ctrl : 8'h00;

  // Read data is captured one cycle after the strobe and then held
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_sel;
    end
  end

  // --------------------------------------------------------------------
  // Power-good trees
  // --------------------------------------------------------------------
  // shared source follows the factory variant
  logic shared_pg;
  assign shared_pg = SHARED_IS_SWITCH ? load_switch_b2_pg
                                      : aux_regulator_1_pg;

  // Output 3 sources, in mask bit order 7 down to 0, then ctl 3 and 6
  logic [9:0] o3_src;
  logic [9:0] o3_mask;
  assign o3_src = {control_input_5, control_input_4, control_input_2,
                   control_input_1, ddr_termination_regulator_pg,
                   shared_pg, load_switch_b1_pg, aux_regulator_3_pg,
                   control_input_3, control_input_6};
  assign o3_mask = {out3_mask2[`PGTM_B_O3_CONTROL_INPUT_5],
                    out3_mask2[`PGTM_B_O3_CONTROL_INPUT_4],
                    out3_mask2[`PGTM_B_O3_CONTROL_INPUT_2],
                    out3_mask2[`PGTM_B_O3_CONTROL_INPUT_1],
                    out3_mask2[`PGTM_B_O3_TERM],
                    out3_mask2[`PGTM_B_O3_SHARED],
                    out3_mask2[`PGTM_B_O3_LOAD_SWITCH_B1],
                    out3_mask2[`PGTM_B_O3_AUX3],
                    ctl_mask[`PGTM_B_O3_CONTROL_INPUT_3],
                    ctl_mask[`PGTM_B_O3_CONTROL_INPUT_6]};

  // Outputs 1, 2 and 4 see only control inputs 3 and 6 here
  logic [1:0] ctl36_src;
  logic [1:0] o1_mask;
  logic [1:0] o2_mask;
  logic [1:0] o4_mask;
  assign ctl36_src = {control_input_3, control_input_6};
  assign o1_mask = {ctl_mask[`PGTM_B_O1_CONTROL_INPUT_3], ctl_mask[`PGTM_B_O1_CONTROL_INPUT_6]};
  assign o2_mask = {ctl_mask[`PGTM_B_O2_CONTROL_INPUT_3], ctl_mask[`PGTM_B_O2_CONTROL_INPUT_6]};
  assign o4_mask = {ctl_mask[`PGTM_B_O4_CONTROL_INPUT_3], ctl_mask[`PGTM_B_O4_CONTROL_INPUT_6]};

  logic tree_1;
  logic tree_2;
  logic tree_3;
  logic tree_4;

  pgtm_pg_tree #(.N(2)) u_tree_1 (
    .src_good   (ctl36_src),
    .src_mask   (o1_mask),
    .other_good (other_tree_good_1),
    .tree_good  (tree_1)
  );
  pgtm_pg_tree #(.N(2)) u_tree_2 (
    .src_good   (ctl36_src),
    .src_mask   (o2_mask),
    .other_good (other_tree_good_2),
    .tree_good  (tree_2)
  );
  pgtm_pg_tree #(.N(10)) u_tree_3 (
    .src_good   (o3_src),
    .src_mask   (o3_mask),
    .other_good (other_tree_good_3),
    .tree_good  (tree_3)
  );
  pgtm_pg_tree #(.N(2)) u_tree_4 (
    .src_good   (ctl36_src),
    .src_mask   (o4_mask),
    .other_good (other_tree_good_4),
    .tree_good  (tree_4)
  );

  // Pins are registered so a glitch in the tree never reaches a pin
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pg_output_1 <= 1'b0;
      pg_output_2 <= 1'b0;
      pg_output_3 <= 1'b0;
      pg_output_4 <= 1'b0;
    end else begin
      pg_output_1 <= tree_1;
      pg_output_2 <= tree_2;
      pg_output_3 <= tree_3;
      pg_output_4 <= tree_4;
    end
  end

  // --------------------------------------------------------------------
  // Discharge and voltage fields
  // --------------------------------------------------------------------
  // termination discharge select
  assign termination_discharge_sel = term_disch[`PGTM_B_TERM_DISCH];
  // discharge code in bits 7 and 6
  assign aux1_discharge_sel =
    aux_sw_ctrl[`PGTM_B_AUX_DISCH_HI:`PGTM_B_AUX_DISCH_LO];
  assign aux1_voltage_code = aux_sw_ctrl[`PGTM_B_VCODE_HI:`PGTM_B_VCODE_LO];

  // --------------------------------------------------------------------
  // Emergency shutdown hold-off
  // --------------------------------------------------------------------
  pgtm_pkg::pgtm_sdwn_state_e sd_state;
  pgtm_pkg::pgtm_sdwn_state_e next_sd_state;
  logic [SDWN_CNT_W-1:0]      sd_cnt;
  logic [SDWN_CNT_W-1:0]      next_sd_cnt;
  logic                       esd_prev;
  logic                       esd_rise;
  logic                       sdwn_cfg;

  assign sdwn_cfg = aux_sw_ctrl[`PGTM_B_SDWN_CFG];
  // Only a new request starts a hold-off, a held level does not repeat
  assign esd_rise = emergency_shutdown & ~esd_prev;

  always_comb begin
    next_sd_state = sd_state;
    next_sd_cnt   = sd_cnt;
    case (sd_state)
      pgtm_pkg::PGTM_SD_IDLE: begin
        if (esd_rise && !sdwn_cfg) begin
          next_sd_state = pgtm_pkg::PGTM_SD_HOLD;
          next_sd_cnt   = SDWN_LOAD;
        end
      end
      pgtm_pkg::PGTM_SD_HOLD: begin
        if (sd_cnt == '0) begin
          next_sd_state = pgtm_pkg::PGTM_SD_IDLE;
        end else begin
          next_sd_cnt = sd_cnt - 1'b1;
        end
      end
      default: begin
        next_sd_state = pgtm_pkg::PGTM_SD_IDLE;
        next_sd_cnt   = '0;
      end
    endcase
  end

  // State, counter and edge history
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sd_state <= pgtm_pkg::PGTM_SD_IDLE;
      sd_cnt   <= '0;
      esd_prev <= 1'b0;
    end else begin
      sd_state <= next_sd_state;
      sd_cnt   <= next_sd_cnt;
      esd_prev <= emergency_shutdown;
    end
  end

  // enable bit drives the output in variants 0 and 3, forced off during hold-off
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_or_switch_on <= 1'b0;
    end else begin
      aux_or_switch_on <= AUX_SW_USED & aux_sw_ctrl[`PGTM_B_AUX_EN] &
                          (next_sd_state != pgtm_pkg::PGTM_SD_HOLD);
    end
  end

endmodule

// >>> pkg/pgtm_defines.svh
// Offsets, field positions, reset values and timing for the pg tree slice
`ifndef PGTM_DEFINES_SVH
`define PGTM_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PGTM_OFF_OUT3_MASK2   8'hab
`define PGTM_OFF_CTL_MASK     8'hac
`define PGTM_OFF_TERM_DISCH   8'had
`define PGTM_OFF_AUX_SW_CTRL  8'hae

// ----------------------------------------------------------------------
// Field positions, second output-3 mask register
// ----------------------------------------------------------------------
`define PGTM_B_O3_CONTROL_INPUT_5        7
`define PGTM_B_O3_CONTROL_INPUT_4        6
`define PGTM_B_O3_CONTROL_INPUT_2        5
`define PGTM_B_O3_CONTROL_INPUT_1        4
`define PGTM_B_O3_TERM        3
`define PGTM_B_O3_SHARED      2
`define PGTM_B_O3_LOAD_SWITCH_B1        1
`define PGTM_B_O3_AUX3        0

// ----------------------------------------------------------------------
// Field positions, control input mask register
// ----------------------------------------------------------------------
`define PGTM_B_O1_CONTROL_INPUT_3        7
`define PGTM_B_O1_CONTROL_INPUT_6        6
`define PGTM_B_O4_CONTROL_INPUT_3        5
`define PGTM_B_O4_CONTROL_INPUT_6        4
`define PGTM_B_O2_CONTROL_INPUT_3        3
`define PGTM_B_O2_CONTROL_INPUT_6        2
`define PGTM_B_O3_CONTROL_INPUT_3        1
`define PGTM_B_O3_CONTROL_INPUT_6        0

// ----------------------------------------------------------------------
// Field positions, discharge and aux/switch control
// ----------------------------------------------------------------------
`define PGTM_B_TERM_DISCH     4
`define PGTM_B_AUX_DISCH_HI   7
`define PGTM_B_AUX_DISCH_LO   6
`define PGTM_B_SDWN_CFG       5
`define PGTM_B_VCODE_HI       4
`define PGTM_B_VCODE_LO       1
`define PGTM_B_AUX_EN         0

// ----------------------------------------------------------------------
// Factory defaults per variant (index 0 to 3)
// ----------------------------------------------------------------------
`define PGTM_RST_OUT3_MASK2_V0 8'hbf
`define PGTM_RST_OUT3_MASK2_V1 8'heb
`define PGTM_RST_OUT3_MASK2_V2 8'hef
`define PGTM_RST_OUT3_MASK2_V3 8'hdf
`define PGTM_RST_CTL_MASK_V0   8'hab
`define PGTM_RST_CTL_MASK_V1   8'hff
`define PGTM_RST_CTL_MASK_V2   8'hee
`define PGTM_RST_CTL_MASK_V3   8'hef
`define PGTM_RST_TERM_DISCH_V0 8'h5f
`define PGTM_RST_TERM_DISCH_V1 8'h5f
`define PGTM_RST_TERM_DISCH_V2 8'h5f
`define PGTM_RST_TERM_DISCH_V3 8'h5c
`define PGTM_RST_AUX_SW_V0     8'h54
`define PGTM_RST_AUX_SW_V1     8'h48
`define PGTM_RST_AUX_SW_V2     8'h48
`define PGTM_RST_AUX_SW_V3     8'h48

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PGTM_CLK_PERIOD_NS    10
`define PGTM_NS_PER_MS        1000000
`define PGTM_T_SDWN_MIN_MS    1
`define PGTM_T_SDWN_MAX_MS    100

`endif

// >>> pkg/pgtm_pkg.sv
// Types shared by the pg tree slice
package pgtm_pkg;

  // Register contents
  typedef logic [7:0] pgtm_byte_t;

  // Emergency shutdown hold-off states
  typedef enum logic [1:0] {
    PGTM_SD_IDLE = 2'b01,
    PGTM_SD_HOLD = 2'b10
  } pgtm_sdwn_state_e;

endpackage

// >>> verilog/pgtm_reg8.sv
// Byte-wide read/write register with factory reset value
`timescale 1ns/1ps
module pgtm_reg8 #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // Stored value
  output logic      [7:0] value
);

  // Reset loads the factory default, a write replaces all eight bits
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      value <= RESET_VAL;
    end else if (wr_en) begin
      value <= wr_data;
    end
  end

endmodule

// >>> verilog/pgtm_pg_tree.sv
// Masked AND tree for one power-good output
`timescale 1ns/1ps
module pgtm_pg_tree #(
  parameter int N = 2
) (
  // Sources and their masks, a set mask bit drops the source
  input  wire logic [N-1:0] src_good,
  input  wire logic [N-1:0] src_mask,
  // Combined result of sources masked outside this slice
  input  wire logic         other_good,
  // Tree result
  output logic              tree_good
);

  // Elaboration check
  initial begin
    if (N < 1) begin
      $error("pgtm_pg_tree needs at least one source");
    end
  end

  // Masked sources read as good so they cannot pull the tree low
  assign tree_good = other_good & (&(src_good | src_mask));

endmodule

// >>> bench/pgtm_top_props.sv
// Port-level checks for the pg tree slice
`timescale 1ns/1ps
`include "pgtm_defines.svh"
module pgtm_top_props #(
  parameter int SDWN_CYCLES = 8
) (
  // Clock, reset and register port
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Tree and control pins
  input wire logic       other_tree_good_3,
  input wire logic       pg_output_3,
  input wire logic       emergency_shutdown,
  input wire logic       termination_discharge_sel,
  input wire logic [1:0] aux1_discharge_sel,
  input wire logic [3:0] aux1_voltage_code,
  input wire logic       aux_or_switch_on
);
  // Shadow reset assumes variant 0, the only one this bench builds
  localparam pgtm_pkg::pgtm_byte_t AUX_RST = `PGTM_RST_AUX_SW_V0;
  // The hold-off span sequence is written out for eight cycles
  initial begin
    if (SDWN_CYCLES != 8) begin
      $error("pgtm_top_props: hold-off span expects 8 cycles");
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Decoded accesses
  wire wr_term = reg_wr && reg_addr == `PGTM_OFF_TERM_DISCH;
  wire wr_aux  = reg_wr && reg_addr == `PGTM_OFF_AUX_SW_CTRL;
  wire rd_none = reg_rd && (reg_addr < `PGTM_OFF_OUT3_MASK2 ||
                            reg_addr > `PGTM_OFF_AUX_SW_CTRL);
  // Shutdown config is internal, so it is mirrored from the writes
  logic sd_cfg;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sd_cfg <= AUX_RST[5];
    end else if (wr_aux) begin
      sd_cfg <= reg_wdata[5];
    end
  end
  sequence sd_trig;
    $rose(emergency_shutdown) && aux_or_switch_on && !wr_aux && !sd_cfg;
  endsequence
  sequence sd_off_span;
    !aux_or_switch_on [*8] ##1 aux_or_switch_on;
  endsequence
  chk_term_disch_wr: assert property (
    wr_term |=> termination_discharge_sel == $past(reg_wdata[4]))
    else $error("termination discharge select wrong");
  chk_aux_vcode_wr: assert property (
    wr_aux |=> aux1_voltage_code == $past(reg_wdata[4:1]))
    else $error("voltage code wrong");
  chk_aux_disch_wr: assert property (
    wr_aux |=> aux1_discharge_sel == $past(reg_wdata[7:6]))
    else $error("aux discharge select wrong");
  chk_fields_hold: assert property (
    !wr_aux |=> $stable(aux1_voltage_code) && $stable(aux1_discharge_sel))
    else $error("aux fields moved without a write");
  chk_unmapped_read: assert property (
    rd_none |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_out3_other: assert property (
    pg_output_3 |-> $past(other_tree_good_3))
    else $error("output 3 high with outside tree bad");
  chk_enable_off: assert property (
    wr_aux && !reg_wdata[0] |-> ##2 !aux_or_switch_on)
    else $error("output on after enable cleared");
  chk_sd_hold_span: assert property (
    sd_trig |=> sd_off_span)
    else $error("shutdown hold-off span wrong");
  chk_sd_cfg_ignore: assert property (
    $rose(emergency_shutdown) && aux_or_switch_on && !wr_aux && sd_cfg
    |=> aux_or_switch_on)
    else $error("shutdown acted with config set");
endmodule

// >>> bench/pgtm_top_test.sv
// Self-checking bench for the pg tree slice
`timescale 1ns/1ps
`include "pgtm_defines.svh"
module pgtm_top_test;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  localparam int SDWN = 8;
  logic       sys_clk;
  logic       rst_b;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  // Out3 sources in mask order: aux3,b1,shared,term,c1,c2,c4,c5,c6,c3
  logic [9:0] good_src;
  logic       switch_b2_good;
  logic [3:0] other_good;
  logic       emergency_shutdown;
  logic [3:0] out_good;
  logic       termination_discharge_sel;
  logic [1:0] aux1_discharge_sel;
  logic [3:0] aux1_voltage_code;
  logic       aux_or_switch_on;
  int         errors;
  int         total_checks;
  pgtm_top #(.VARIANT(0), .SDWN_CYCLES(SDWN)) pgtm_top_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .control_input_1(good_src[4]),
    .control_input_2(good_src[5]), .control_input_3(good_src[9]),
    .control_input_4(good_src[6]), .control_input_5(good_src[7]),
    .control_input_6(good_src[8]),
    .ddr_termination_regulator_pg(good_src[3]),
    .load_switch_b1_pg(good_src[1]), .load_switch_b2_pg(switch_b2_good),
    .aux_regulator_1_pg(good_src[2]), .aux_regulator_3_pg(good_src[0]),
    .other_tree_good_1(other_good[0]), .other_tree_good_2(other_good[1]),
    .other_tree_good_3(other_good[2]), .other_tree_good_4(other_good[3]),
    .emergency_shutdown(emergency_shutdown),
    .pg_output_1(out_good[0]), .pg_output_2(out_good[1]),
    .pg_output_3(out_good[2]), .pg_output_4(out_good[3]),
    .termination_discharge_sel(termination_discharge_sel),
    .aux1_discharge_sel(aux1_discharge_sel),
    .aux1_voltage_code(aux1_voltage_code),
    .aux_or_switch_on(aux_or_switch_on));
  // Free-running clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // Strobes last one cycle, ending on a falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask
  // Pins register the tree results, so allow a full cycle to land
  task automatic settle;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic count_off(input logic [7:0] exp);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (aux_or_switch_on !== 1'b1 && n < 40) begin
      n++;
      @(negedge sys_clk);
    end
    chk(8'(n), exp);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_values;
    rd_chk(`PGTM_OFF_OUT3_MASK2, `PGTM_RST_OUT3_MASK2_V0);
    rd_chk(`PGTM_OFF_CTL_MASK, `PGTM_RST_CTL_MASK_V0);
    rd_chk(`PGTM_OFF_TERM_DISCH, `PGTM_RST_TERM_DISCH_V0);
    rd_chk(`PGTM_OFF_AUX_SW_CTRL, `PGTM_RST_AUX_SW_V0);
    chk({aux1_discharge_sel, 1'b0, aux1_voltage_code, aux_or_switch_on},
        `PGTM_RST_AUX_SW_V0);
    wr(8'haf, 8'hff);
    rd_chk(8'haf, 8'h00);
    rd_chk(`PGTM_OFF_AUX_SW_CTRL, `PGTM_RST_AUX_SW_V0);
    $display("test reset_values done");
  endtask
  // Each source drops the tree until its own mask bit is set
  task automatic test_out3_tree;
    logic [9:0] m;
    for (int i = 0; i < 10; i++) begin
      m = 10'h001 << i;
      wr(`PGTM_OFF_OUT3_MASK2, 8'h00);
      wr(`PGTM_OFF_CTL_MASK, 8'h00);
      good_src[i] = 1'b0;
      settle();
      chk({7'h00, out_good[2]}, 8'h00);
      wr(`PGTM_OFF_OUT3_MASK2, m[7:0]);
      wr(`PGTM_OFF_CTL_MASK, {6'h00, m[9:8]});
      settle();
      chk({7'h00, out_good[2]}, 8'h01);
      good_src[i] = 1'b1;
    end
    wr(`PGTM_OFF_OUT3_MASK2, 8'h00);
    switch_b2_good = 1'b0;
    settle();
    chk({7'h00, out_good[2]}, 8'h01);
    other_good[2] = 1'b0;
    settle();
    chk({7'h00, out_good[2]}, 8'h00);
    other_good[2] = 1'b1;
    switch_b2_good = 1'b1;
    $display("test out3_tree done");
  endtask
  // Mask bits 7..2 pair outputs 1,4,2 with the two shared inputs
  task automatic test_ctl_masks;
    int o;
    for (int b = 2; b < 8; b++) begin
      o = (b >= 6) ? 0 : (b >= 4) ? 3 : 1;
      wr(`PGTM_OFF_CTL_MASK, 8'h00);
      good_src[b[0] ? 9 : 8] = 1'b0;
      settle();
      chk({7'h00, out_good[o]}, 8'h00);
      wr(`PGTM_OFF_CTL_MASK, 8'h01 << b);
      settle();
      chk({7'h00, out_good[o]}, 8'h01);
      good_src[8] = 1'b1;
      good_src[9] = 1'b1;
    end
    $display("test ctl_masks done");
  endtask
  task automatic test_fields;
    logic [7:0] v;
    v = `PGTM_RST_TERM_DISCH_V0 & 8'hef;
    wr(`PGTM_OFF_TERM_DISCH, v);
    chk({7'h00, termination_discharge_sel}, 8'h00);
    rd_chk(`PGTM_OFF_TERM_DISCH, v);
    wr(`PGTM_OFF_TERM_DISCH, v | 8'h10);
    chk({7'h00, termination_discharge_sel}, 8'h01);
    for (int d = 0; d < 4; d++) begin
      v = {2'(d), 1'b0, 4'(5 * d), 1'b0};
      wr(`PGTM_OFF_AUX_SW_CTRL, v);
      chk({aux1_discharge_sel, 1'b0, aux1_voltage_code, 1'b0}, v);
      rd_chk(`PGTM_OFF_AUX_SW_CTRL, v);
    end
    $display("test fields done");
  endtask
  // Hold-off, a rise inside it, then config set and enable cleared
  task automatic test_shutdown;
    wr(`PGTM_OFF_AUX_SW_CTRL, 8'h01);
    // The enable pin is registered behind the register itself
    @(negedge sys_clk);
    chk({7'h00, aux_or_switch_on}, 8'h01);
    emergency_shutdown = 1'b1;
    count_off(8'(SDWN));
    emergency_shutdown = 1'b0;
    settle();
    emergency_shutdown = 1'b1;
    repeat (3) @(negedge sys_clk);
    emergency_shutdown = 1'b0;
    @(negedge sys_clk);
    emergency_shutdown = 1'b1;
    count_off(8'(SDWN - 4));
    emergency_shutdown = 1'b0;
    wr(`PGTM_OFF_AUX_SW_CTRL, 8'h21);
    settle();
    emergency_shutdown = 1'b1;
    count_off(8'h00);
    emergency_shutdown = 1'b0;
    wr(`PGTM_OFF_AUX_SW_CTRL, 8'h20);
    @(negedge sys_clk);
    chk({7'h00, aux_or_switch_on}, 8'h00);
    $display("test shutdown done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence, all inputs set at time zero
  initial begin
    errors = 0;
    total_checks = 0;
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    good_src = 10'h3ff;
    switch_b2_good = 1'b1;
    other_good = 4'hf;
    emergency_shutdown = 1'b0;
    repeat (16) @(negedge sys_clk);
    rst_b = 1'b1;
    test_reset_values();
    test_out3_tree();
    test_ctl_masks();
    test_fields();
    test_shutdown();
    tally_and_finish();
  end
  // Tests take about 260 cycles; this allows over seventy times that
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
endmodule
bind pgtm_top pgtm_top_props #(.SDWN_CYCLES(SDWN_CYCLES)) pgtm_top_props_i (
  .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .other_tree_good_3(other_tree_good_3),
  .pg_output_3(pg_output_3), .emergency_shutdown(emergency_shutdown),
  .termination_discharge_sel(termination_discharge_sel),
  .aux1_discharge_sel(aux1_discharge_sel),
  .aux1_voltage_code(aux1_voltage_code),
  .aux_or_switch_on(aux_or_switch_on));
